// >>> verilog/pssc_top.sv
// power switch state controller: global state, switch timing, wake, fans, ac-loss restore
`timescale 1ns/100ps
`default_nettype none
`include "pssc_cfg.svh"

// Contract
// R01 - From soft-off a press released before four seconds brings the system to working.
// R02 - From working a press released before four seconds puts the system to sleep.
// R03 - From working a hold of four seconds forces soft-off without software.
// R04 - From sleep a press released before four seconds wakes the system to working.
// R05 - From sleep a hold of four seconds sends the system straight to soft-off.
// R06 - A soft-off request from the operating system powers the system down to soft-off.
// R07 - Fans run in working and processor-stopped sleep and are off otherwise.
// R08 - Switch, alarm and wake line wake from S1/S3/S4/S5; keyboard, usb and modem only from S1/S3.
// R09 - LAN and pme wakes from soft-off work only when their option is set.
// R10 - After ac loss the system returns to its last on/off state, subject to the last-state setting.
// R11 - Presses are timed by a counter; a hold of the threshold or more is long, a short press acts at release.
module pssc_top #(
   parameter int unsigned HOLD_CYCLES = `PSSC_HOLD_CYCLES
) (
   input  wire logic       mclk,
   input  wire logic       rst_n,
   input  wire logic       pwr_sw,
   input  wire logic       os_off_req,
   input  wire logic       os_sleep_req,
   input  wire logic [1:0] os_sleep_type,
   input  wire logic       wake_rtc,
   input  wire logic       wake_line,
   input  wire logic       wake_kbd,
   input  wire logic       wake_usb,
   input  wire logic       wake_modem,
   input  wire logic       wake_lan,
   input  wire logic       wake_pme,
   input  wire logic       s5_wake_en,
   input  wire logic [1:0] last_state_mode,
   input  wire logic       last_was_on,
   output logic            sys_on,
   output logic            sys_sleep,
   output logic [4:0]      sys_state,
   output logic            fan_en,
   output logic            state_saved_on
);
   localparam int CW = $clog2(HOLD_CYCLES + 1);
   localparam logic [CW-1:0] HOLD_MAX = CW'(HOLD_CYCLES);

   // inputs from the board are asynchronous to mclk
   logic [8:0] raw_in;
   logic [8:0] sync_in;
   assign raw_in = {pwr_sw, wake_rtc, wake_line, wake_kbd, wake_usb, wake_modem, wake_lan, wake_pme, os_off_req};

   genvar gi;
   generate
      for (gi = 0; gi < 9; gi++) begin : g_sync
         pssc_sync u_sync (
            .mclk  (mclk),
            .rst_n (rst_n),
            .din   (raw_in[gi]),
            .dout  (sync_in[gi])
         );
      end
   endgenerate

   logic sw, w_rtc, w_line, w_kbd, w_usb, w_modem, w_lan, w_pme, off_req;
   assign {sw, w_rtc, w_line, w_kbd, w_usb, w_modem, w_lan, w_pme, off_req} = sync_in;

   typedef struct packed {
      pssc_pkg::pssc_state_t state;
      logic [CW-1:0]         hold_cnt;
      logic                  sw_prev;
      logic                  long_done;
      logic                  restored;
      logic                  was_on;
      logic                  fan;
      logic                  on_o;
      logic                  sleep_o;
   } pssc_reg_t;

   pssc_reg_t r;
   pssc_reg_t next_r;

   logic wake_any;
   logic wake_deep;
   logic wake_shallow;
   logic short_rel;
   logic long_hit;
   pssc_pkg::pssc_state_t tgt;

   always_comb begin
      next_r       = r;
      tgt          = r.state;
      // hold counter saturates so a very long hold never wraps into a short one
      short_rel    = r.sw_prev && !sw && !r.long_done; // [R11]
      long_hit     = sw && !r.long_done && (r.hold_cnt == HOLD_MAX - CW'(1)); // [R11]
      wake_deep    = w_rtc || w_line; // [R08]
      wake_shallow = w_kbd || w_usb || w_modem; // [R08]
      wake_any     = 1'b0;
      case (r.state)
         pssc_pkg::PSSC_OFF: wake_any = wake_deep || (s5_wake_en && (w_lan || w_pme)); // [R08] [R09]
         pssc_pkg::PSSC_S4:  wake_any = wake_deep || w_lan || w_pme; // [R08]
         pssc_pkg::PSSC_S1,
         pssc_pkg::PSSC_S3:  wake_any = wake_deep || wake_shallow || w_lan || w_pme; // [R08]
         default:            wake_any = 1'b0;
      endcase

      next_r.sw_prev = sw;
      if (sw) begin
         if (r.hold_cnt != HOLD_MAX) begin
            next_r.hold_cnt = r.hold_cnt + CW'(1);
         end
         if (long_hit) begin
            next_r.long_done = 1'b1;
         end
      end else begin
         next_r.hold_cnt  = '0;
         next_r.long_done = 1'b0;
      end

      case (r.state)
         pssc_pkg::PSSC_OFF: begin
            if (!r.restored) begin
               // 2'h0 stay off, 2'h1 always on, else last state
               case (last_state_mode)
                  2'h0:    tgt = pssc_pkg::PSSC_OFF;
                  2'h1:    tgt = pssc_pkg::PSSC_S0;
                  default: tgt = last_was_on ? pssc_pkg::PSSC_S0 : pssc_pkg::PSSC_OFF; // [R10]
               endcase
               next_r.restored = 1'b1;
            end else if (short_rel || wake_any) begin
               tgt = pssc_pkg::PSSC_S0; // [R01] [R08]
            end
         end
         pssc_pkg::PSSC_S0: begin
            if (long_hit || off_req) begin
               tgt = pssc_pkg::PSSC_OFF; // [R03] [R06]
            end else if (short_rel) begin
               tgt = pssc_pkg::PSSC_S1; // [R02]
            end else if (os_sleep_req) begin
               case (os_sleep_type)
                  2'h1:    tgt = pssc_pkg::PSSC_S3;
                  2'h2:    tgt = pssc_pkg::PSSC_S4;
                  default: tgt = pssc_pkg::PSSC_S1;
               endcase
            end
         end
         pssc_pkg::PSSC_S1,
         pssc_pkg::PSSC_S3,
         pssc_pkg::PSSC_S4: begin
            if (long_hit || off_req) begin
               tgt = pssc_pkg::PSSC_OFF; // [R05] [R06]
            end else if (short_rel || wake_any) begin
               tgt = pssc_pkg::PSSC_S0; // [R04] [R08]
            end
         end
         default: tgt = pssc_pkg::PSSC_OFF;
      endcase

      next_r.state   = tgt;
      next_r.fan     = (tgt == pssc_pkg::PSSC_S0) || (tgt == pssc_pkg::PSSC_S1); // [R07]
      next_r.on_o    = (tgt == pssc_pkg::PSSC_S0);
      next_r.sleep_o = (tgt == pssc_pkg::PSSC_S1) || (tgt == pssc_pkg::PSSC_S3) || (tgt == pssc_pkg::PSSC_S4);
      // sleep counts as on for ac-loss restore
      next_r.was_on  = (tgt != pssc_pkg::PSSC_OFF); // [R10]
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         r       <= '0;
         r.state <= pssc_pkg::PSSC_OFF;
      end else begin
         r <= next_r;
      end
   end

   assign sys_on         = r.on_o;
   assign sys_sleep      = r.sleep_o;
   assign sys_state      = r.state;
   assign fan_en         = r.fan;
   assign state_saved_on = r.was_on;

   fan_state_a: assert property (@(posedge mclk) disable iff (!rst_n)
      fan_en == (sys_state == pssc_pkg::PSSC_S0 || sys_state == pssc_pkg::PSSC_S1))
      else $error("fan enable disagrees with state"); // [R07]

   sequence s_short_off;
      r.state == pssc_pkg::PSSC_OFF && r.restored && short_rel;
   endsequence
   short_on_a: assert property (@(posedge mclk) disable iff (!rst_n)
      s_short_off |=> sys_state == pssc_pkg::PSSC_S0)
      else $error("short press from off did not power on"); // [R01]

   short_sleep_a: assert property (@(posedge mclk) disable iff (!rst_n)
      (r.state == pssc_pkg::PSSC_S0 && short_rel && !long_hit && !off_req) |=> sys_state == pssc_pkg::PSSC_S1)
      else $error("short press in working did not sleep"); // [R02]

   long_off_a: assert property (@(posedge mclk) disable iff (!rst_n)
      (r.state == pssc_pkg::PSSC_S0 && long_hit) |=> sys_state == pssc_pkg::PSSC_OFF)
      else $error("long hold in working did not force off"); // [R03]

   short_wake_a: assert property (@(posedge mclk) disable iff (!rst_n)
      (r.sleep_o && short_rel && !off_req) |=> sys_on)
      else $error("short press in sleep did not wake"); // [R04]

   sleep_off_a: assert property (@(posedge mclk) disable iff (!rst_n)
      (r.sleep_o && long_hit) |=> sys_state == pssc_pkg::PSSC_OFF)
      else $error("long hold in sleep did not power off"); // [R05]

   os_off_a: assert property (@(posedge mclk) disable iff (!rst_n)
      (off_req && r.state != pssc_pkg::PSSC_OFF) |=> sys_state == pssc_pkg::PSSC_OFF)
      else $error("os off request ignored"); // [R06]

   s5_lan_a: assert property (@(posedge mclk) disable iff (!rst_n)
      (r.state == pssc_pkg::PSSC_OFF && r.restored && !s5_wake_en && !sw && !r.sw_prev && !wake_deep) |=>
      sys_state == pssc_pkg::PSSC_OFF)
      else $error("wake from off without an enabled source"); // [R08] [R09]

   long_count_a: assert property (@(posedge mclk) disable iff (!rst_n)
      long_hit |-> r.hold_cnt == HOLD_MAX - CW'(1) && $past(sw))
      else $error("long hold flagged at wrong count"); // [R11]

   restore_a: assert property (@(posedge mclk) disable iff (!rst_n)
      (rst_n && !r.restored && last_state_mode == 2'h1) |=> sys_on)
      else $error("always-on restore failed"); // [R10]
endmodule : pssc_top
`default_nettype wire

// >>> verilog/pssc_cfg.svh
// timing constants and synchroniser depth for the power switch state controller
`ifndef PSSC_CFG_SVH
`define PSSC_CFG_SVH
`define PSSC_CLK_MHZ        125
`define PSSC_HOLD_SEC       4
`define PSSC_HOLD_CYCLES    (`PSSC_HOLD_SEC * `PSSC_CLK_MHZ * 1000000)
`define PSSC_SYNC_STAGES    2
`endif

// >>> verilog/pssc_pkg.sv
// types for the power switch state controller
package pssc_pkg;
   typedef enum logic [4:0] {
      PSSC_OFF = 5'h01,
      PSSC_S0  = 5'h02,
      PSSC_S1  = 5'h04,
      PSSC_S3  = 5'h08,
      PSSC_S4  = 5'h10
   } pssc_state_t;
   typedef enum logic [1:0] {
      PSSC_SLP_S1 = 2'h0,
      PSSC_SLP_S3 = 2'h1,
      PSSC_SLP_S4 = 2'h2
   } pssc_sleep_t;
endpackage : pssc_pkg

// >>> verilog/pssc_sync.sv
// two-flop synchroniser for one asynchronous level
`timescale 1ns/100ps
`default_nettype none
module pssc_sync (
   input  wire logic mclk,
   input  wire logic rst_n,
   input  wire logic din,
   output logic      dout
);
   typedef struct packed {
      logic meta;
      logic out;
   } pssc_sync_t;
   pssc_sync_t r;
   pssc_sync_t next_r;

   always_comb begin
      next_r.meta = din;
      next_r.out  = r.meta;
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         r <= '0;
      end else begin
         r <= next_r;
      end
   end

   assign dout = r.out;
endmodule : pssc_sync
`default_nettype wire

// >>> verif/pssc_panel.sv
// front panel switch and os power request model
`timescale 1ns/100ps
`default_nettype none
module pssc_panel (
   input  wire logic       mclk,
   input  wire logic [4:0] sys_state,
   output logic            pwr_sw,
   output logic            os_off_req
);
   initial begin
      pwr_sw     <= 1'b0;
      os_off_req <= 1'b0;
   end
   // debounced level, held n edges; settles well past the 3 edge answer
   task automatic press(input int n);
      @(posedge mclk) pwr_sw <= 1'b1;
      repeat (n) @(posedge mclk);
      pwr_sw <= 1'b0;
      repeat (8) @(posedge mclk);
   endtask : press
   // request stays up until off is shown, bounded so a dead design cannot hang it
   task automatic os_off();
      int i;
      @(posedge mclk) os_off_req <= 1'b1;
      for (i = 0; i < 20 && sys_state !== 5'h01; i++) @(posedge mclk);
      os_off_req <= 1'b0;
      repeat (3) @(posedge mclk);
   endtask : os_off
endmodule : pssc_panel
`default_nettype wire

// >>> verif/tb_top.sv
// self-checking bench for the power switch state controller
`timescale 1ns/100ps
`default_nettype none
module tb_top;
   logic       mclk = 1'b0;
   logic       rst_n, os_sleep_req, s5_wake_en, last_was_on;
   logic [1:0] os_sleep_type, last_state_mode;
   logic [6:0] wk; // rtc line kbd usb modem lan pme
   logic       pwr_sw, os_off_req, sys_on, sys_sleep, fan_en, state_saved_on;
   logic [4:0] sys_state;
   int         num_errors = 0, checks_done = 0, cyc = 0;
   always #4 mclk = ~mclk;
   pssc_top #(.HOLD_CYCLES(20)) i_dut (.mclk(mclk), .rst_n(rst_n), .pwr_sw(pwr_sw), .os_off_req(os_off_req),
      .os_sleep_req(os_sleep_req), .os_sleep_type(os_sleep_type), .wake_rtc(wk[6]), .wake_line(wk[5]),
      .wake_kbd(wk[4]), .wake_usb(wk[3]), .wake_modem(wk[2]), .wake_lan(wk[1]), .wake_pme(wk[0]),
      .s5_wake_en(s5_wake_en), .last_state_mode(last_state_mode), .last_was_on(last_was_on),
      .sys_on(sys_on), .sys_sleep(sys_sleep), .sys_state(sys_state), .fan_en(fan_en),
      .state_saved_on(state_saved_on));
   pssc_panel i_panel (.mclk(mclk), .sys_state(sys_state), .pwr_sw(pwr_sw), .os_off_req(os_off_req));
   task automatic chk(input string nm, input logic [4:0] seen, input logic [4:0] exp);
      checks_done++;
      if (seen !== exp) begin
         num_errors++;
         $display("mismatch %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   task automatic results();
      if (num_errors == 0 && checks_done > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : results
   task automatic rst(input logic [1:0] mode, input logic last);
      @(posedge mclk);
      rst_n           <= 1'b0;
      last_state_mode <= mode;
      last_was_on     <= last;
      repeat (4) @(posedge mclk);
      rst_n <= 1'b1;
      repeat (4) @(posedge mclk);
   endtask : rst
   task automatic sleep(input logic [1:0] t);
      @(posedge mclk);
      os_sleep_type <= t;
      os_sleep_req  <= 1'b1;
      @(posedge mclk) os_sleep_req <= 1'b0;
      repeat (4) @(posedge mclk);
   endtask : sleep
   task automatic wake(input logic [6:0] b, input logic [4:0] exp);
      @(posedge mclk) wk <= b;
      repeat (6) @(posedge mclk);
      chk("wake state", sys_state, exp);
      wk <= 7'h00;
      repeat (4) @(posedge mclk);
   endtask : wake
   task automatic t_switch();
      rst(2'h0, 1'b0);
      chk("reset state", sys_state, 5'h01);
      i_panel.press(5);
      chk("on state", sys_state, 5'h02);
      chk("on fan", {3'h0, sys_on, fan_en}, 5'h03);
      i_panel.press(5);
      chk("sleep state", sys_state, 5'h04);
      chk("s1 fan", {3'h0, sys_sleep, fan_en}, 5'h03);
      i_panel.press(5);
      chk("woken state", sys_state, 5'h02);
      i_panel.press(30);
      chk("forced off", sys_state, 5'h01);
      chk("off outputs", {2'h0, sys_on, fan_en, state_saved_on}, 5'h00);
   endtask : t_switch
   task automatic t_sleep_long();
      i_panel.press(5);
      sleep(2'h1);
      chk("s3 state", sys_state, 5'h08);
      chk("s3 fan", {4'h0, fan_en}, 5'h00);
      i_panel.press(30);
      chk("sleep long", sys_state, 5'h01);
   endtask : t_sleep_long
   task automatic t_os();
      i_panel.press(5);
      i_panel.os_off();
      chk("os off", sys_state, 5'h01);
   endtask : t_os
   task automatic t_wake();
      wake(7'h1C, 5'h01);
      wake(7'h03, 5'h01);
      wake(7'h40, 5'h02);
      i_panel.os_off();
      wake(7'h20, 5'h02);
      for (int i = 2; i < 5; i++) begin
         sleep(i == 2 ? 2'h0 : 2'h1);
         wake(7'h01 << i, 5'h02);
      end
      sleep(2'h2);
      wake(7'h1C, 5'h10);
      wake(7'h01, 5'h02);
      i_panel.os_off();
      s5_wake_en <= 1'b1;
      wake(7'h02, 5'h02);
   endtask : t_wake
   task automatic t_restore();
      rst(2'h2, 1'b1);
      chk("restore on", sys_state, 5'h02);
      chk("saved on", {4'h0, state_saved_on}, 5'h01);
      rst(2'h2, 1'b0);
      chk("restore off", sys_state, 5'h01);
      rst(2'h1, 1'b0);
      chk("power on", sys_state, 5'h02);
   endtask : t_restore
   // ceiling far above the few hundred cycles the scenarios need
   always @(posedge mclk) begin
      cyc++;
      if (cyc == 20000) begin
         num_errors++;
         results();
      end
   end
   initial begin
      rst_n           <= 1'b0;
      os_sleep_req    <= 1'b0;
      s5_wake_en      <= 1'b0;
      last_was_on     <= 1'b0;
      os_sleep_type   <= 2'h0;
      last_state_mode <= 2'h0;
      wk              <= 7'h00;
      t_switch();
      t_sleep_long();
      t_os();
      t_wake();
      t_restore();
      results();
   end
endmodule : tb_top
`default_nettype wire
